//--- src/plc_pkg.sv
// Constants, field layouts and frame helpers for the power-line command sender
package plc_pkg;

    // ---------------------------------------------------------------
    // Clock and carrier timing
    // ---------------------------------------------------------------
    localparam int CLK_HZ     = 250_000_000;
    localparam int CARRIER_HZ = 120_000;
    // Half carrier period in clocks, rounded down
    localparam int CAR_HALF   = CLK_HZ / (2 * CARRIER_HZ);
    localparam int BURST_US   = 1000;
    localparam int BURST_CYC  = BURST_US * (CLK_HZ / 1_000_000);

    // ---------------------------------------------------------------
    // Register bus
    // ---------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] A_CMD    = 4'h0;
    localparam logic [ADDR_W-1:0] A_PINSEL = 4'h4;
    localparam logic [ADDR_W-1:0] A_STATUS = 4'h8;

    // Command word fields
    localparam int HOUSE_LSB = 0;
    localparam int HOUSE_W   = 4;
    localparam int KEY_LSB   = 4;
    localparam int KEY_W     = 5;
    localparam int REP_LSB   = 9;
    localparam int REP_W     = 8;
    localparam int TOG_BIT   = 17;
    localparam int ENTRY_W   = 18;

    // Pin select fields
    localparam int NPINS    = 16;
    localparam int PIN_W    = 4;
    localparam int MPIN_LSB = 0;
    localparam int ZPIN_LSB = 4;

    // Status fields
    localparam int ST_BUSY    = 0;
    localparam int ST_FULL    = 1;
    localparam int ST_EMPTY   = 2;
    localparam int ST_LVL_LSB = 4;
    localparam int FIFO_DEPTH = 8;
    localparam int LVL_W      = 4;

    // ---------------------------------------------------------------
    // Keys and framing
    // ---------------------------------------------------------------
    // Function key codes
    localparam logic [KEY_W-1:0] unit_on_key       = 5'h12;
    localparam logic [KEY_W-1:0] unit_off_key      = 5'h1a;
    localparam logic [KEY_W-1:0] all_units_off_key = 5'h1c;
    localparam logic [KEY_W-1:0] all_lamps_on_key  = 5'h14;
    localparam logic [KEY_W-1:0] dim_key           = 5'h1e;
    localparam logic [KEY_W-1:0] bright_key        = 5'h16;
    localparam logic [KEY_W-1:0] TOGGLE_MASK       = 5'h08;
    localparam logic [REP_W-1:0] DEFAULT_REP       = 8'h02;
    localparam logic [REP_W-1:0] REP_ONE           = 8'h01;

    localparam int START_W   = 4;
    localparam int DATA_BITS = 9;
    localparam int HALF_BITS = 22;
    localparam logic [START_W-1:0] START_PAT = 4'he;
    localparam logic [4:0] HB_LAST   = 5'h15;
    localparam logic [2:0] GAP_XINGS = 3'h6;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_GAP  = 2'b01,
        ST_SEND = 2'b10
    } tx_state_e;

    // Start pattern, then each data bit as true and complement half-bits
    function automatic logic [HALF_BITS-1:0] frame_bits(input logic [HOUSE_W-1:0] h,
                                                       input logic [KEY_W-1:0]   k);
        logic [DATA_BITS-1:0] d;
        logic [HALF_BITS-1:0] f;
        d = {h, k};
        f = {START_PAT, {(HALF_BITS-START_W){1'b0}}};
        for (int i = 0; i < DATA_BITS; i++)
        begin
            f[HALF_BITS-START_W-1-2*i] = d[DATA_BITS-1-i];
            f[HALF_BITS-START_W-2-2*i] = ~d[DATA_BITS-1-i];
        end
        return f;
    endfunction

    // One-hot pin mask
    function automatic logic [NPINS-1:0] pin_bit(input logic [PIN_W-1:0] p);
        logic [NPINS-1:0] m;
        m = '0;
        m[p] = 1'b1;
        return m;
    endfunction

endpackage

//--- src/cmd_fifo.sv
// Parameterised command FIFO with valid/ready on both sides
`timescale 1ns/100ps
module cmd_fifo #(
    parameter int W = 18,
    parameter int D = 8
) (
    input  wire logic                 mclk,
    input  wire logic                 rst,
    input  wire logic                 in_valid,
    output logic                      in_ready,
    input  wire logic [W-1:0]         in_data,
    output logic                      out_valid,
    input  wire logic                 out_ready,
    output logic [W-1:0]              out_data,
    output logic [$clog2(D+1)-1:0]    level
);
    localparam int AW = $clog2(D);
    localparam int CW = $clog2(D+1);

    logic [W-1:0]  mem [D];
    logic [AW-1:0] wptr_ff, nxt_wptr;
    logic [AW-1:0] rptr_ff, nxt_rptr;
    logic [CW-1:0] cnt_ff,  nxt_cnt;
    logic          push;
    logic          take;

    // ---------------------------------------------------------------
    // Handshakes
    // ---------------------------------------------------------------
    assign in_ready  = (cnt_ff != CW'(D));
    assign out_valid = (cnt_ff != '0);
    assign out_data  = mem[rptr_ff];
    assign level     = cnt_ff;
    assign push      = in_valid && in_ready;
    assign take      = out_valid && out_ready;

    // Pointer and count update, wrapping at depth
    always_comb
    begin
        nxt_wptr = wptr_ff;
        nxt_rptr = rptr_ff;
        nxt_cnt  = cnt_ff;
        if (push)
            nxt_wptr = (wptr_ff == AW'(D-1)) ? '0 : wptr_ff + 1'b1;
        if (take)
            nxt_rptr = (rptr_ff == AW'(D-1)) ? '0 : rptr_ff + 1'b1;
        if (push && !take)
            nxt_cnt = cnt_ff + 1'b1;
        else if (take && !push)
            nxt_cnt = cnt_ff - 1'b1;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            wptr_ff <= '0;
            rptr_ff <= '0;
            cnt_ff  <= '0;
        end
        else
        begin
            wptr_ff <= nxt_wptr;
            rptr_ff <= nxt_rptr;
            cnt_ff  <= nxt_cnt;
        end
    end

    // Storage, written on accepted push
    always_ff @(posedge mclk)
    begin
        if (push)
            mem[wptr_ff] <= in_data;
    end
endmodule

//--- src/carrier_burst.sv
// Carrier burst generator: timed burst gated by a carrier-rate divider
`timescale 1ns/100ps
module carrier_burst
    import plc_pkg::*;
#(
    parameter int BURST_LEN = plc_pkg::BURST_CYC
) (
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic start,
    output logic      car_on
);
    localparam int BW = $clog2(BURST_LEN);
    localparam int DW = $clog2(CAR_HALF);

    logic [BW-1:0] left_ff,  nxt_left;
    logic [DW-1:0] div_ff,   nxt_div;
    logic          burst_ff, nxt_burst;
    logic          phase_ff, nxt_phase;
    logic          tick;

    // Half-period enable pulse from the divider
    assign tick   = (div_ff == DW'(CAR_HALF - 1));
    assign car_on = burst_ff && phase_ff;

    // Start restarts burst with carrier high at once
    always_comb
    begin
        nxt_left  = left_ff;
        nxt_div   = div_ff;
        nxt_burst = burst_ff;
        nxt_phase = phase_ff;
        if (start)
        begin
            nxt_burst = 1'b1;
            nxt_left  = BW'(BURST_LEN - 1);
            nxt_div   = '0;
            nxt_phase = 1'b1;
        end
        else if (burst_ff)
        begin
            if (left_ff == '0)
                nxt_burst = 1'b0;
            else
                nxt_left = left_ff - 1'b1;
            nxt_div   = tick ? '0 : div_ff + 1'b1;
            nxt_phase = tick ? ~phase_ff : phase_ff;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            left_ff  <= '0;
            div_ff   <= '0;
            burst_ff <= 1'b0;
            phase_ff <= 1'b0;
        end
        else
        begin
            left_ff  <= nxt_left;
            div_ff   <= nxt_div;
            burst_ff <= nxt_burst;
            phase_ff <= nxt_phase;
        end
    end
endmodule

//--- src/power_line_send.sv
// Power-line command sender: register port, command queue, framer and pins
`timescale 1ns/100ps
// What this block does
// - Drive selected modulation pin as output
// - Make selected zero-cross pin input, sample it
// - Four-bit house code in every frame
// - Five-bit key, units or function keys
// - Fixed codes for the six function keys
// - Repeat count 1..255, default two
// - Busy until sent; waits forever without crossings
// - Carrier bursts at zero crossings mark bits
// - Bursts aligned to crossings within 50 us
// - Eleven-bit code sequence per command
// - Toggle bit flips on/off key bit
module power_line_send #(
    parameter int BURST_LEN = plc_pkg::BURST_CYC
) (
    input  wire logic                        mclk,
    input  wire logic                        rst,
    input  wire logic [plc_pkg::ADDR_W-1:0]  addr,
    input  wire logic [plc_pkg::DATA_W-1:0]  wdata,
    input  wire logic                        wr,
    input  wire logic                        rd,
    output logic      [plc_pkg::DATA_W-1:0]  rdata,
    input  wire logic [plc_pkg::NPINS-1:0]   io_in,
    output logic      [plc_pkg::NPINS-1:0]   io_out,
    output logic      [plc_pkg::NPINS-1:0]   io_oe
);
    import plc_pkg::*;

    logic [NPINS-1:0]     zs1_ff, zs2_ff;
    logic                 zlast_ff;
    logic                 zc_now, zc_edge;
    logic [PIN_W-1:0]     mpin_ff, nxt_mpin;
    logic [PIN_W-1:0]     zpin_ff, nxt_zpin;
    logic [NPINS-1:0]     oe_ff,   nxt_oe;
    logic [NPINS-1:0]     out_ff,  nxt_out;
    logic [DATA_W-1:0]    rdata_ff, nxt_rdata;
    tx_state_e            state_ff, nxt_state;
    logic [HALF_BITS-1:0] shift_ff, nxt_shift;
    logic [4:0]           hb_ff,    nxt_hb;
    logic [REP_W-1:0]     rep_ff,   nxt_rep;
    logic [HOUSE_W-1:0]   house_ff, nxt_house;
    logic [KEY_W-1:0]     key_ff,   nxt_key;
    logic [2:0]           gap_ff,   nxt_gap;
    logic                 prev_ff,  nxt_prev;
    logic                 busy_ff,  nxt_busy;
    logic                 pop, fire, car_on;
    logic                 wr_cmd, wr_pin;
    logic                 f_ready, f_valid;
    logic [ENTRY_W-1:0]   f_data;
    logic [LVL_W-1:0]     f_level;
    logic [HOUSE_W-1:0]   ent_house;
    logic [KEY_W-1:0]     ent_key;
    logic [REP_W-1:0]     ent_rep;

    // ---------------------------------------------------------------
    // Zero-crossing input
    // ---------------------------------------------------------------
    // Two-stage synchroniser on every pin input
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            zs1_ff   <= '0;
            zs2_ff   <= '0;
            zlast_ff <= 1'b0;
        end
        else
        begin
            zs1_ff   <= io_in;
            zs2_ff   <= zs1_ff;
            zlast_ff <= zc_now;
        end
    end

    // Either edge of the selected input is a crossing
    assign zc_now  = zs2_ff[zpin_ff];
    assign zc_edge = (zc_now != zlast_ff);

    // ---------------------------------------------------------------
    // Command queue
    // ---------------------------------------------------------------
    assign wr_cmd = wr && (addr == A_CMD);
    assign wr_pin = wr && (addr == A_PINSEL) && (state_ff == ST_IDLE) && !f_valid;

    cmd_fifo #(
        .W (ENTRY_W),
        .D (FIFO_DEPTH)
    ) u_fifo (
        .mclk      (mclk),
        .rst       (rst),
        .in_valid  (wr_cmd),
        .in_ready  (f_ready),
        .in_data   (wdata[ENTRY_W-1:0]),
        .out_valid (f_valid),
        .out_ready (pop),
        .out_data  (f_data),
        .level     (f_level)
    );

    // Entry decode: toggle flips on/off, zero count means default
    assign ent_house = f_data[HOUSE_LSB +: HOUSE_W];
    assign ent_key   = f_data[KEY_LSB +: KEY_W]
                       ^ (f_data[TOG_BIT] ? TOGGLE_MASK : '0);
    assign ent_rep   = (f_data[REP_LSB +: REP_W] == '0) ? DEFAULT_REP
                       : f_data[REP_LSB +: REP_W];

    // ---------------------------------------------------------------
    // Framer state machine
    // ---------------------------------------------------------------
    always_comb
    begin
        nxt_state = state_ff;
        nxt_shift = shift_ff;
        nxt_hb    = hb_ff;
        nxt_rep   = rep_ff;
        nxt_house = house_ff;
        nxt_key   = key_ff;
        nxt_gap   = gap_ff;
        nxt_prev  = prev_ff;
        nxt_oe    = oe_ff;
        pop       = 1'b0;
        fire      = 1'b0;
        case (state_ff)
            ST_IDLE:
            begin
                if (f_valid)
                begin
                    pop       = 1'b1;
                    nxt_house = ent_house;
                    nxt_key   = ent_key;
                    nxt_rep   = ent_rep;
                    nxt_shift = frame_bits(ent_house, ent_key);
                    nxt_hb    = '0;
                    nxt_oe    = (oe_ff | pin_bit(mpin_ff)) & ~pin_bit(zpin_ff);
                    if (prev_ff && ({ent_house, ent_key} != {house_ff, key_ff}))
                    begin
                        nxt_state = ST_GAP;
                        nxt_gap   = GAP_XINGS;
                    end
                    else
                        nxt_state = ST_SEND;
                end
                else
                    nxt_prev = 1'b0;
            end
            ST_GAP:
            begin
                // Count crossings with no carrier
                if (zc_edge)
                begin
                    nxt_gap = gap_ff - 1'b1;
                    if (gap_ff == 3'h1)
                        nxt_state = ST_SEND;
                end
            end
            ST_SEND:
            begin
                // One half-bit per crossing; stalls with no crossings
                if (zc_edge)
                begin
                    fire      = shift_ff[HALF_BITS-1];
                    nxt_shift = {shift_ff[HALF_BITS-2:0], 1'b0};
                    nxt_hb    = hb_ff + 1'b1;
                    if (hb_ff == HB_LAST)
                    begin
                        if (rep_ff == REP_ONE)
                        begin
                            nxt_state = ST_IDLE;
                            nxt_prev  = 1'b1;
                        end
                        else
                        begin
                            nxt_rep   = rep_ff - 1'b1;
                            nxt_shift = frame_bits(house_ff, key_ff);
                            nxt_hb    = '0;
                        end
                    end
                end
            end
            default:
                nxt_state = ST_IDLE;
        endcase
    end

    // Busy covers queued, gapping and sending
    assign nxt_busy = (nxt_state != ST_IDLE) || f_valid || (wr_cmd && f_ready);

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            state_ff <= ST_IDLE;
            shift_ff <= '0;
            hb_ff    <= '0;
            rep_ff   <= '0;
            house_ff <= '0;
            key_ff   <= '0;
            gap_ff   <= '0;
            prev_ff  <= 1'b0;
            oe_ff    <= '0;
            busy_ff  <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            shift_ff <= nxt_shift;
            hb_ff    <= nxt_hb;
            rep_ff   <= nxt_rep;
            house_ff <= nxt_house;
            key_ff   <= nxt_key;
            gap_ff   <= nxt_gap;
            prev_ff  <= nxt_prev;
            oe_ff    <= nxt_oe;
            busy_ff  <= nxt_busy;
        end
    end

    // ---------------------------------------------------------------
    // Carrier and pins
    // ---------------------------------------------------------------
    carrier_burst #(
        .BURST_LEN (BURST_LEN)
    ) u_car (
        .mclk   (mclk),
        .rst    (rst),
        .start  (fire),
        .car_on (car_on)
    );

    // Carrier only on the modulation pin
    assign nxt_out = car_on ? pin_bit(mpin_ff) : '0;

    // ---------------------------------------------------------------
    // Register port
    // ---------------------------------------------------------------
    always_comb
    begin
        nxt_mpin  = mpin_ff;
        nxt_zpin  = zpin_ff;
        nxt_rdata = '0;
        if (wr_pin)
        begin
            nxt_mpin = wdata[MPIN_LSB +: PIN_W];
            nxt_zpin = wdata[ZPIN_LSB +: PIN_W];
        end
        if (rd)
        begin
            case (addr)
                A_CMD:
                    nxt_rdata = DATA_W'({key_ff, house_ff});
                A_PINSEL:
                begin
                    nxt_rdata[MPIN_LSB +: PIN_W] = mpin_ff;
                    nxt_rdata[ZPIN_LSB +: PIN_W] = zpin_ff;
                end
                A_STATUS:
                begin
                    nxt_rdata[ST_BUSY]              = busy_ff;
                    nxt_rdata[ST_FULL]              = !f_ready;
                    nxt_rdata[ST_EMPTY]             = !f_valid;
                    nxt_rdata[ST_LVL_LSB +: LVL_W]  = f_level;
                end
                default:
                    nxt_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            mpin_ff  <= '0;
            zpin_ff  <= '0;
            rdata_ff <= '0;
            out_ff   <= '0;
        end
        else
        begin
            mpin_ff  <= nxt_mpin;
            zpin_ff  <= nxt_zpin;
            rdata_ff <= nxt_rdata;
            out_ff   <= nxt_out;
        end
    end

    assign rdata  = rdata_ff;
    assign io_out = out_ff;
    assign io_oe  = oe_ff;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    sequence s_fire;
        state_ff == ST_SEND && zc_edge && shift_ff[HALF_BITS-1];
    endsequence

    sequence s_burst_out;
        car_on ##1 io_out[mpin_ff];
    endsequence

    AST_MOD_OE: assert property (state_ff != ST_IDLE |-> io_oe[mpin_ff])
        else $error("modulation pin not driven while sending");
    AST_ZC_IN: assert property (state_ff != ST_IDLE && zpin_ff != mpin_ff |-> !io_oe[zpin_ff])
        else $error("zero-cross pin driven while sending");
    AST_LOAD: assert property (pop |=> house_ff == $past(ent_house) && state_ff != ST_IDLE)
        else $error("house code not loaded");
    AST_TOGGLE: assert property (pop && f_data[TOG_BIT] |=> key_ff == ($past(f_data[KEY_LSB +: KEY_W]) ^ TOGGLE_MASK))
        else $error("toggle did not flip key");
    AST_DEFAULT_REP: assert property (pop && f_data[REP_LSB +: REP_W] == '0 |=> rep_ff == DEFAULT_REP)
        else $error("default repeat count not two");
    AST_STALL: assert property (state_ff == ST_SEND && !zc_edge |=> state_ff == ST_SEND && hb_ff == $past(hb_ff) && busy_ff)
        else $error("frame advanced without a crossing");
    AST_ALIGN: assert property (s_fire |-> ##1 s_burst_out)
        else $error("burst not started at crossing");
    AST_REPEAT: assert property (state_ff == ST_SEND && zc_edge && hb_ff == HB_LAST && rep_ff != REP_ONE
                                 |=> hb_ff == '0 && shift_ff == frame_bits(house_ff, key_ff))
        else $error("frame not restarted for repeat");
    AST_COMPL: assert property (state_ff == ST_SEND && hb_ff >= 5'(START_W) && !hb_ff[0]
                                |-> shift_ff[HALF_BITS-1] != shift_ff[HALF_BITS-2])
        else $error("data half-bits not complementary");
    AST_GAP: assert property (pop && prev_ff && {ent_house, ent_key} != {house_ff, key_ff}
                              |=> state_ff == ST_GAP && gap_ff == GAP_XINGS)
        else $error("no idle gap between commands");
    AST_GAP_QUIET: assert property (state_ff == ST_GAP |-> !fire)
        else $error("burst started during gap");
endmodule

//--- dv/plc_line_model.sv
// Power-line interface model: crossing source and burst detector
`timescale 1ns/100ps
module plc_line_model #(
    parameter int HALF = 130
) (
    input  wire logic        mclk,
    input  wire logic        en,
    input  wire logic [3:0]  mpin,
    input  wire logic [15:0] io_out,
    input  wire logic [15:0] io_oe,
    output logic             zc
);
    logic got[$];
    logic seen;

    // --------------------------------------
    // Crossings while enabled, one sample each
    // --------------------------------------
    initial
    begin
        zc = 1'b0;
        forever
        begin
            repeat (HALF - 20) @(posedge mclk);
            if (en)
            begin
                zc <= ~zc;
                seen = 1'b0;
                repeat (20) @(posedge mclk) seen |= io_out[mpin] & io_oe[mpin];
                got.push_back(seen);
            end
        end
    end
endmodule

//--- dv/powerline_command_sender_test.sv
// Self-checking bench for the power-line command sender
`timescale 1ns/100ps
module powerline_command_sender_test;
    import plc_pkg::*;
    logic        mclk;
    logic        rst;
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic [15:0] io_in;
    logic [15:0] io_out;
    logic [15:0] io_oe;
    logic [15:0] pins;
    logic        zc;
    logic        en;
    logic [3:0]  mp;
    logic [3:0]  zp;
    logic [31:0] st;
    logic        exp_q[$];
    logic [8:0]  prev;
    logic [4:0]  fk[6] = '{5'h12, 5'h1a, 5'h1c, 5'h14, 5'h1e, 5'h16};
    int          seed = 94;
    int          errors = 0;
    int          num_checks = 0;
    int          cyc = 0;

    // ----------------
    // Clock, pins, parts
    // ----------------
    initial mclk = 1'b0;
    always #2 mclk = ~mclk;

    // Zero-cross line laid over idle pins
    always_comb
    begin
        io_in = pins;
        io_in[zp] = zc;
    end

    power_line_send #(.BURST_LEN(100)) i_dut (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .io_in(io_in), .io_out(io_out), .io_oe(io_oe));
    plc_line_model #(.HALF(130)) i_line (.mclk(mclk), .en(en), .mpin(mp), .io_out(io_out), .io_oe(io_oe),
        .zc(zc));

    // ----------------
    // Tasks
    // ----------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk);
        wr    <= 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk);
        rd   <= 1'b0;
        #1;
        d = rdata;
    endtask

    // Half-bits expected on the line for one queued command
    function automatic void add_cmd(input logic [3:0] h, input logic [4:0] k, input int n);
        logic [8:0] d;
        d = {h, k};
        if (exp_q.size() != 0 && d != prev)
            repeat (6) exp_q.push_back(1'b0);
        prev = d;
        repeat (n)
        begin
            for (int i = 3; i >= 0; i--)
                exp_q.push_back(i != 0);
            for (int i = 8; i >= 0; i--)
            begin
                exp_q.push_back(d[i]);
                exp_q.push_back(~d[i]);
            end
        end
    endfunction

    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Cut a hang short
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 80000)
        begin
            errors++;
            stop_test();
        end
    end

    // ----------------
    // Main sequence
    // ----------------
    initial
    begin
        logic [3:0] h;
        logic [4:0] k;
        logic [7:0] r;
        logic       t;
        rst = 1'b1;
        addr = '0;
        wdata = '0;
        wr = 1'b0;
        rd = 1'b0;
        en = 1'b0;
        mp = 4'h0;
        zp = 4'h0;
        pins = 16'($random(seed));
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        rd_reg(A_STATUS, st);
        chk(st, 32'h4);
        rd_reg(4'hc, st);
        chk(st, 32'h0);
        chk(32'(io_oe), 32'h0);
        mp = 4'($random(seed));
        zp = mp ^ 4'h8;
        wr_reg(A_PINSEL, {24'h0, zp, mp});
        rd_reg(A_PINSEL, st);
        chk(st, {24'h0, zp, mp});
        // Queue filled on a dead line; tenth entry must be dropped
        for (int i = 0; i < 10; i++)
        begin
            h = 4'($random(seed));
            k = (i < 6) ? fk[i] : (i == 6) ? 5'($random(seed) & 15) : (i == 7) ? 5'h12 : 5'h1e;
            r = (i == 8) ? 8'h03 : 8'((i & 1) << 1);
            t = (i == 7);
            wr_reg(A_CMD, {14'h0, t, r, k, h});
            if (i < 9)
                add_cmd(h, t ? 5'h1a : k, (r == 0) ? 2 : int'(r));
        end
        repeat (500) @(posedge mclk);
        rd_reg(A_STATUS, st);
        chk(st, 32'h83);
        wr_reg(A_PINSEL, 32'h0);
        rd_reg(A_PINSEL, st);
        chk(st, {24'h0, zp, mp});
        en = 1'b1;
        st = '1;
        for (int n = 0; n < 2000 && st[0] !== 1'b0; n++)
        begin
            repeat (64) @(posedge mclk);
            rd_reg(A_STATUS, st);
        end
        chk(st, 32'h4);
        chk(32'(io_oe), 32'(16'h1 << mp));
        rd_reg(A_CMD, st);
        chk(st, {23'h0, prev[4:0], prev[8:5]});
        repeat (520) @(posedge mclk);
        en <= 1'b0;
        repeat (200) @(posedge mclk);
        chk(32'(i_line.got.size() >= exp_q.size()), 32'h1);
        foreach (i_line.got[i])
            chk(32'(i_line.got[i]), (i < exp_q.size()) ? 32'(exp_q[i]) : 32'h0);
        stop_test();
    end
endmodule
